// ===== src/ext_bus_strobe_pkg.sv
// Constants for the external bus strobe timing generator.
// Assumes a 32-bit Avalon-MM slave with byte addresses, word aligned.
package ext_bus_strobe_pkg;

	// Register byte offsets.
	localparam logic [4:0] off_flash_wait  = 5'h00;
	localparam logic [4:0] off_lcd_wait    = 5'h04;
	localparam logic [4:0] off_sys_ctrl    = 5'h08;
	localparam logic [4:0] off_flash_ctrl  = 5'h0c;
	localparam logic [4:0] off_access_cmd  = 5'h10;
	localparam logic [4:0] off_access_data = 5'h14;

	// Wait-state register field positions.
	localparam int trail_lsb = 0;
	localparam int trail_msb = 4;
	localparam int width_lsb = 5;
	localparam int width_msb = 10;
	localparam int hshake_bit = 11;
	localparam int lead_lsb = 12;
	localparam int lead_msb = 15;
	localparam int wait_msb = 15;

	// System control fields.
	localparam int sdram_sel_bit = 0;
	localparam int gen_pol_bit   = 1;
	localparam int flash_pol_bit = 2;
	localparam int sys_msb       = 2;

	// Flash control field.
	localparam int chip_sel_bit = 0;

	// Access command fields: bit 0 target, bit 1 write, address above.
	localparam int cmd_lcd_bit   = 0;
	localparam int cmd_write_bit = 1;
	localparam int cmd_addr_lsb  = 8;
	localparam int cmd_addr_msb  = 23;
	localparam int busy_bit      = 31;

	// Values after reset.
	localparam logic [15:0] wait_reset = 16'h0000;
	localparam logic [2:0]  sys_reset  = 3'h0;

	// Bus widths on the pin side, and the timing counter width.
	localparam int data_w = 16;
	localparam int addr_w = 16;
	localparam int cnt_w  = 6;

	typedef enum logic [1:0] {
		st_idle,
		st_lead,
		st_strobe,
		st_trail
	} phase_t;

endpackage : ext_bus_strobe_pkg

// ===== src/ext_bus_strobe_timing.sv
// Strobe timing generator for flash and LCD on the shared parallel bus.
// Assumes clk at 10 MHz, sys_rst synchronous; ready and data_in are pins.
//
// Contract
// [RL1] Handshake bit: ready stretches strobe, fields ignored.
// [RL2] Flash lead clocks from select to strobe.
// [RL3] Flash strobe width in clocks, zero is one.
// [RL4] Flash trailing clocks, five-bit field, zero one.
// [RL5] LCD lead clocks from select to strobe.
// [RL6] LCD strobe width in clocks.
// [RL7] LCD trailing clocks to select release, zero one.
// [RL8] Select bit gives muxes to outer or SDRAM.
// [RL9] General polarity bit inverts read/write strobes.
// [RL10] Flash polarity bit inverts flash strobes.
// [RL11] Chip select bit picks flash chip one/zero.
// [RL12] Order: select, lead, strobe, trail, release.
`timescale 1ns/1ns
`default_nettype none

module ext_bus_strobe_timing (
	input  wire logic        clk,                 // 10 MHz clock.
	input  wire logic        sys_rst,             // Synchronous reset.
	input  wire logic [4:0]  avs_address,         // Byte address.
	input  wire logic        avs_read,            // Read request.
	input  wire logic        avs_write,           // Write request.
	input  wire logic [31:0] avs_writedata,       // Write data.
	output logic      [31:0] avs_readdata,        // Read data.
	output logic             avs_waitrequest,     // Stall, low answers.
	input  wire logic        ready,               // Device ready pin.
	input  wire logic [15:0] data_in,             // Data bus input pin.
	output logic      [15:0] data_out,            // Data bus output.
	output logic             data_oe,             // Data bus enable.
	output logic      [15:0] addr_out,            // Address bus output.
	input  wire logic [15:0] sdram_addr,          // SDRAM address.
	input  wire logic [15:0] sdram_data,          // SDRAM write data.
	input  wire logic        sdram_data_oe,       // SDRAM data enable.
	output logic             inner_sdram_controller, // Muxes to SDRAM.
	output logic      [1:0]  flash_select_n,      // Flash selects.
	output logic             flash_read_strobe_n, // Flash read strobe.
	output logic             flash_write_strobe_n, // Flash write strobe.
	output logic             lcd_select_n,        // LCD select.
	output logic             read_strobe_n,       // LCD read strobe.
	output logic             write_strobe_n       // LCD write strobe.
);

	// Zero in a timing field behaves as one.
	function automatic logic [5:0] eff(input logic [5:0] v);
		eff = (v == 6'h00) ? 6'h01 : v;
	endfunction : eff

	// Lead and trailing counts; handshake mode uses one clock for each.
	function automatic logic [5:0] lead(input logic [15:0] w);
		lead = w[ext_bus_strobe_pkg::hshake_bit] ? 6'h01 // RL1
			: eff({2'b00, w[15:12]}); // RL2 RL5
	endfunction : lead

	function automatic logic [5:0] trail(input logic [15:0] w);
		trail = w[ext_bus_strobe_pkg::hshake_bit] ? 6'h01 // RL1
			: eff({1'b0, w[4:0]}); // RL4 RL7
	endfunction : trail

	logic        ready_m_q, ready_s_q;
	logic [15:0] din_m_q, din_s_q;
	logic [15:0] fwait_q, fwait_d, lwait_q, lwait_d;
	logic [2:0]  sys_q, sys_d;
	logic        fsel_q, fsel_d;
	logic [31:0] cmd_q, cmd_d;
	logic [15:0] wdat_q, wdat_d, rdat_q, rdat_d;
	logic        start_q, start_d;
	logic [31:0] rd_q, rd_d;
	logic        wr_q, wr_d;
	ext_bus_strobe_pkg::phase_t ph_q, ph_d;
	logic [5:0]  cnt_q, cnt_d;
	logic        lcd_q, lcd_d, dir_q, dir_d;
	logic        cs_q, cs_d, stb_q, stb_d;
	logic [15:0] wsel;
	logic        busy;

	// Pin inputs pass two flip-flops before any logic reads them.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			ready_m_q <= 1'b0;
			ready_s_q <= 1'b0;
			din_m_q   <= 16'h0000;
			din_s_q   <= 16'h0000;
		end
		else
		begin
			ready_m_q <= ready;
			ready_s_q <= ready_m_q;
			din_m_q   <= data_in;
			din_s_q   <= din_m_q;
		end
	end

	assign busy = (ph_q != ext_bus_strobe_pkg::st_idle) | start_q;

	// Register file and bus slave; a command write stalls while busy.
	always_comb
	begin
		fwait_d = fwait_q;
		lwait_d = lwait_q;
		sys_d   = sys_q;
		fsel_d  = fsel_q;
		cmd_d   = cmd_q;
		wdat_d  = wdat_q;
		start_d = 1'b0;
		rd_d    = rd_q;
		wr_d    = 1'b1;
		if ((avs_read | avs_write) & wr_q)
		begin
			if (!(avs_write & busy &
			    (avs_address == ext_bus_strobe_pkg::off_access_cmd)))
				wr_d = 1'b0;
			case (avs_address)
				ext_bus_strobe_pkg::off_flash_wait:
					rd_d = {16'h0000, fwait_q};
				ext_bus_strobe_pkg::off_lcd_wait:
					rd_d = {16'h0000, lwait_q};
				ext_bus_strobe_pkg::off_sys_ctrl:
					rd_d = {29'h00000000, sys_q};
				ext_bus_strobe_pkg::off_flash_ctrl:
					rd_d = {31'h00000000, fsel_q};
				ext_bus_strobe_pkg::off_access_cmd:
					rd_d = {busy, cmd_q[30:0]};
				ext_bus_strobe_pkg::off_access_data:
					rd_d = {16'h0000, rdat_q};
				default:
					rd_d = 32'h00000000;
			endcase
		end
		if (avs_write & !wr_q)
		begin
			case (avs_address)
				ext_bus_strobe_pkg::off_flash_wait:
					fwait_d = avs_writedata[15:0];
				ext_bus_strobe_pkg::off_lcd_wait:
					lwait_d = avs_writedata[15:0];
				ext_bus_strobe_pkg::off_sys_ctrl:
					sys_d = avs_writedata[2:0];
				ext_bus_strobe_pkg::off_flash_ctrl:
					fsel_d = avs_writedata[0];
				ext_bus_strobe_pkg::off_access_cmd:
				begin
					cmd_d   = {1'b0, avs_writedata[30:0]};
					start_d = 1'b1;
				end
				ext_bus_strobe_pkg::off_access_data:
					wdat_d = avs_writedata[15:0];
				default:
					wdat_d = wdat_q;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			fwait_q <= ext_bus_strobe_pkg::wait_reset;
			lwait_q <= ext_bus_strobe_pkg::wait_reset;
			sys_q   <= ext_bus_strobe_pkg::sys_reset;
			fsel_q  <= 1'b0;
			cmd_q   <= 32'h00000000;
			wdat_q  <= 16'h0000;
			start_q <= 1'b0;
			rd_q    <= 32'h00000000;
			wr_q    <= 1'b1;
		end
		else
		begin
			fwait_q <= fwait_d;
			lwait_q <= lwait_d;
			sys_q   <= sys_d;
			fsel_q  <= fsel_d;
			cmd_q   <= cmd_d;
			wdat_q  <= wdat_d;
			start_q <= start_d;
			rd_q    <= rd_d;
			wr_q    <= wr_d;
		end
	end

	assign wsel = lcd_q ? lwait_q : fwait_q;

	// Access sequencer: select, lead, strobe, trail, then release.
	always_comb
	begin
		ph_d   = ph_q;
		cnt_d  = cnt_q;
		lcd_d  = lcd_q;
		dir_d  = dir_q;
		cs_d   = cs_q;
		stb_d  = stb_q;
		rdat_d = rdat_q;
		case (ph_q) // RL12
			ext_bus_strobe_pkg::st_idle:
			begin
				if (start_q)
				begin
					lcd_d = cmd_q[ext_bus_strobe_pkg::cmd_lcd_bit];
					dir_d = cmd_q[ext_bus_strobe_pkg::cmd_write_bit];
					cs_d  = 1'b1;
					ph_d  = ext_bus_strobe_pkg::st_lead;
					// The chosen set is read here, before lcd_q follows.
					cnt_d = lead(lcd_d ? lwait_q : fwait_q); // RL2 RL5
				end
			end
			ext_bus_strobe_pkg::st_lead:
			begin
				cnt_d = cnt_q - 6'h01;
				if (cnt_d == 6'h00)
				begin
					stb_d = 1'b1;
					ph_d  = ext_bus_strobe_pkg::st_strobe;
					cnt_d = eff(wsel[10:5]); // RL3 RL6
				end
			end
			ext_bus_strobe_pkg::st_strobe:
			begin
				// In handshake mode the count runs free and is not used.
				cnt_d = cnt_q - 6'h01;
				if (wsel[ext_bus_strobe_pkg::hshake_bit] ? ready_s_q // RL1
				    : (cnt_d == 6'h00))
				begin
					stb_d  = 1'b0;
					rdat_d = din_s_q;
					ph_d   = ext_bus_strobe_pkg::st_trail;
					cnt_d  = trail(wsel); // RL4 RL7
				end
			end
			ext_bus_strobe_pkg::st_trail:
			begin
				cnt_d = cnt_q - 6'h01;
				if (cnt_d == 6'h00)
				begin
					cs_d = 1'b0;
					ph_d = ext_bus_strobe_pkg::st_idle;
				end
			end
			default:
				ph_d = ext_bus_strobe_pkg::st_idle;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			ph_q   <= ext_bus_strobe_pkg::st_idle;
			cnt_q  <= 6'h00;
			lcd_q  <= 1'b0;
			dir_q  <= 1'b0;
			cs_q   <= 1'b0;
			stb_q  <= 1'b0;
			rdat_q <= 16'h0000;
		end
		else
		begin
			ph_q   <= ph_d;
			cnt_q  <= cnt_d;
			lcd_q  <= lcd_d;
			dir_q  <= dir_d;
			cs_q   <= cs_d;
			stb_q  <= stb_d;
			rdat_q <= rdat_d;
		end
	end

	assign avs_readdata    = rd_q;
	assign avs_waitrequest = wr_q;

	// Select and strobe pins, and data_oe while the outer controller owns the muxes, are registered from the next-state values.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			inner_sdram_controller <= 1'b0;
			addr_out             <= 16'h0000;
			data_out             <= 16'h0000;
			data_oe              <= 1'b0;
			flash_select_n       <= 2'b11;
			lcd_select_n         <= 1'b1;
			flash_read_strobe_n  <= 1'b1;
			flash_write_strobe_n <= 1'b1;
			read_strobe_n        <= 1'b1;
			write_strobe_n       <= 1'b1;
		end
		else
		begin
			inner_sdram_controller <= sys_q[ext_bus_strobe_pkg::sdram_sel_bit];
			if (sys_q[ext_bus_strobe_pkg::sdram_sel_bit]) // RL8
			begin
				addr_out <= sdram_addr;
				data_out <= sdram_data;
				data_oe  <= sdram_data_oe;
			end
			else
			begin
				addr_out <= cmd_q[23:8];
				data_out <= wdat_q;
				data_oe  <= cs_d & dir_d;
			end
			flash_select_n <= ~({2{cs_d & !lcd_d}} &
				{fsel_q, !fsel_q}); // RL11
			lcd_select_n <= !(cs_d & lcd_d);
			flash_read_strobe_n  <= !(stb_d & !lcd_d & !dir_d) ^
				sys_q[ext_bus_strobe_pkg::flash_pol_bit]; // RL10
			flash_write_strobe_n <= !(stb_d & !lcd_d & dir_d) ^
				sys_q[ext_bus_strobe_pkg::flash_pol_bit]; // RL10
			read_strobe_n  <= !(stb_d & lcd_d & !dir_d) ^
				sys_q[ext_bus_strobe_pkg::gen_pol_bit]; // RL9
			write_strobe_n <= !(stb_d & lcd_d & dir_d) ^
				sys_q[ext_bus_strobe_pkg::gen_pol_bit]; // RL9
		end
	end

endmodule : ext_bus_strobe_timing

`default_nettype wire

// ===== testbench/ext_dev.sv
// Model of the flash or LCD device on the parallel bus.
// Assumes the bench works out which strobe is active.
`timescale 1ns/1ns
`default_nettype none
module ext_dev (
	input  wire logic        clk,     // Clock.
	input  wire logic        sys_rst, // Reset.
	input  wire logic        sel,     // Some select active.
	input  wire logic        stb,     // Some strobe active.
	input  wire logic [3:0]  dly,     // Ready delay.
	output logic             ready,   // Handshake.
	output logic      [15:0] data     // Bus toward block.
);
	logic [3:0] cnt_q;
	logic [3:0] cnt_d;
	// Counts strobe cycles, saturating.
	always_comb cnt_d = !stb ? 4'h0 : cnt_q + {3'h0, cnt_q != 4'hf};
	always_ff @(posedge clk) cnt_q <= sys_rst ? 4'h0 : cnt_d;
	// Ready stretches the strobe until dly cycles passed.
	assign ready = stb && cnt_q >= dly;
	// Pull-ups hold the bus high while nothing is selected.
	assign data = sel ? 16'h5a3c : 16'hffff;
endmodule : ext_dev
`default_nettype wire

// ===== testbench/strobe_chk_props.sv
// Checker for strobe order and mux ownership of the strobe timing block.
// Assumes only the top ports; bound to every instance below.
`timescale 1ns/1ns
`default_nettype none
module strobe_chk (
	input wire logic        clk,                    // Clock.
	input wire logic        sys_rst,                // Reset.
	input wire logic [15:0] addr_out,               // Address.
	input wire logic [15:0] sdram_addr,             // SDRAM address.
	input wire logic        inner_sdram_controller, // Mux owner.
	input wire logic [1:0]  flash_select_n,         // Flash selects.
	input wire logic        flash_read_strobe_n,    // Flash read.
	input wire logic        flash_write_strobe_n,   // Flash write.
	input wire logic        lcd_select_n,           // LCD select.
	input wire logic        read_strobe_n,          // LCD read.
	input wire logic        write_strobe_n          // LCD write.
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic fl_sel;
	logic fl_eq;
	logic lcd_eq;
	// Equal strobes mean neither is active, whatever the polarity.
	assign fl_sel = flash_select_n != 2'h3;
	assign fl_eq = flash_read_strobe_n == flash_write_strobe_n;
	assign lcd_eq = read_strobe_n == write_strobe_n;
	property p_one_chip;
		flash_select_n != 2'h0;
	endproperty
	a_one_chip: assert property (p_one_chip) else $error("two chips");
	property p_excl;
		!(fl_sel && !lcd_select_n);
	endproperty
	a_excl: assert property (p_excl) else $error("two targets");
	property p_fl_lead;
		($fell(fl_sel) or $rose(fl_sel)) |-> fl_eq;
	endproperty
	a_fl_lead: assert property (p_fl_lead) else $error("flash lead");
	property p_lcd_lead;
		$fell(lcd_select_n) |-> lcd_eq;
	endproperty
	a_lcd_lead: assert property (p_lcd_lead) else $error("lcd lead");
	property p_fl_trail;
		$fell(fl_sel) |-> $past(fl_eq);
	endproperty
	a_fl_trail: assert property (p_fl_trail) else $error("fl trail");
	property p_lcd_trail;
		$rose(lcd_select_n) |-> $past(lcd_eq);
	endproperty
	a_lcd_trail: assert property (p_lcd_trail) else $error("trail");
	property p_lcd_idle;
		lcd_select_n && $past(lcd_select_n) |-> lcd_eq;
	endproperty
	a_lcd_idle: assert property (p_lcd_idle) else $error("lcd idle");
	property p_sdram;
		inner_sdram_controller && $past(inner_sdram_controller)
			|-> addr_out == $past(sdram_addr);
	endproperty
	a_sdram: assert property (p_sdram) else $error("sdram mux");
	// Main scenarios reached.
	c_lcd: cover property ($fell(lcd_select_n));
	c_fl: cover property ($rose(fl_sel));
	c_sd: cover property (inner_sdram_controller);
endmodule : strobe_chk
bind ext_bus_strobe_timing strobe_chk u_chk (.*);
`default_nettype wire

// ===== testbench/tb.sv
// Self-checking bench for the strobe timing block.
// Assumes the package, the model and the checker compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic clk, sys_rst, avs_read, avs_write, avs_waitrequest, ready;
	logic [4:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [15:0] data_in, data_out, addr_out, sdram_addr, sdram_data;
	logic [15:0] dev_data;
	logic sdram_data_oe, data_oe, inner_sdram_controller, lcd_select_n;
	logic [1:0] flash_select_n;
	logic flash_read_strobe_n, flash_write_strobe_n;
	logic read_strobe_n, write_strobe_n, sel, stb, pol_f, pol_g;
	logic [3:0] dly;
	int err_total, samples_checked, cyc;
	ext_bus_strobe_timing dut (
		.clk(clk), .sys_rst(sys_rst),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.ready(ready), .data_in(data_in),
		.data_out(data_out), .data_oe(data_oe),
		.addr_out(addr_out), .sdram_addr(sdram_addr),
		.sdram_data(sdram_data), .sdram_data_oe(sdram_data_oe),
		.inner_sdram_controller(inner_sdram_controller),
		.flash_select_n(flash_select_n),
		.flash_read_strobe_n(flash_read_strobe_n),
		.flash_write_strobe_n(flash_write_strobe_n),
		.lcd_select_n(lcd_select_n),
		.read_strobe_n(read_strobe_n),
		.write_strobe_n(write_strobe_n)
	);
	ext_dev dev (.clk(clk), .sys_rst(sys_rst), .sel(sel), .stb(stb),
		.dly(dly), .ready(ready), .data(dev_data));
	// Bus level from both drivers, and what the device sees.
	assign data_in = data_oe ? data_out : dev_data;
	assign sel = !lcd_select_n || flash_select_n != 2'h3;
	assign stb = flash_read_strobe_n == pol_f || flash_write_strobe_n == pol_f
		|| read_strobe_n == pol_g || write_strobe_n == pol_g;
	// Clock.
	initial
	begin
		clk = 0;
		forever #50 clk = ~clk;
	end
	// Cuts a hang short.
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			err_total++;
			report_and_stop();
		end
	end
	task automatic chk(input logic [31:0] g, e);
		samples_checked++;
		if (g !== e)
		begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [4:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		// Only the bench timeout ends this wait.
		do
			@(posedge clk);
		while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 0;
		avs_read <= 0;
	endtask : bus
	task automatic wreg(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1, a, d, q);
	endtask : wreg
	task automatic rdchk(input logic [4:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(0, a, 0, q);
		chk(q, e);
	endtask : rdchk
	task automatic sys(input logic [2:0] v);
		pol_g = v[1];
		pol_f = v[2];
		wreg(5'h08, {29'h0, v});
		repeat (2) @(negedge clk);
	endtask : sys
	function automatic logic [31:0] wv(int l, w, t, logic h);
		return {16'h0, l[3:0], h, w[5:0], t[4:0]};
	endfunction : wv
	// Runs one access and counts lead, strobe and trailing clocks.
	task automatic run_acc(input logic lcd, wr, input logic [31:0] w,
		input int el, ew, et, input logic [1:0] es);
		int ld, wd, tr, n;
		logic s, t, seen;
		ld = 0;
		wd = 0;
		tr = 0;
		seen = 0;
		wreg(lcd ? 5'h04 : 5'h00, w);
		wreg(5'h10, {30'h0, wr, lcd});
		for (n = 0; n < 300; n++)
		begin
			@(negedge clk);
			s = lcd ? !lcd_select_n : flash_select_n != 2'h3;
			t = lcd ? (wr ? write_strobe_n : read_strobe_n) == pol_g
				: (wr ? flash_write_strobe_n : flash_read_strobe_n) == pol_f;
			if (s && !seen && !lcd)
				chk(flash_select_n, es);
			seen = seen || s;
			if (t)
				wd++;
			else if (s && wd == 0)
				ld++;
			else if (s)
				tr++;
			if (seen && !s)
				break;
		end
		chk(ld, el);
		if (ew < 0)
			chk(wd >= -ew, 1);
		else
			chk(wd, ew);
		chk(tr, et);
	endtask : run_acc
	task automatic sc_regs();
		rdchk(5'h00, 32'h0);
		wreg(5'h04, 32'h0000a5c3);
		rdchk(5'h04, 32'h0000a5c3);
		rdchk(5'h1c, 32'h0);
	endtask : sc_regs
	task automatic sc_flash();
		run_acc(0, 0, wv(3, 4, 5, 0), 3, 4, 5, 2'h2);
		wreg(5'h0c, 32'h1);
		run_acc(0, 1, wv(0, 0, 0, 0), 1, 1, 1, 2'h1);
		sys(3'h4);
		chk(flash_read_strobe_n, 0);
		run_acc(0, 0, wv(15, 63, 31, 0), 15, 63, 31, 2'h1);
		sys(3'h0);
		wreg(5'h0c, 32'h0);
	endtask : sc_flash
	task automatic sc_lcd();
		run_acc(1, 1, wv(2, 3, 1, 0), 2, 3, 1, 0);
		run_acc(1, 0, wv(0, 5, 0, 0), 1, 5, 1, 0);
		rdchk(5'h14, 32'h5a3c);
		sys(3'h2);
		chk(read_strobe_n, 0);
		run_acc(1, 1, wv(1, 2, 3, 0), 1, 2, 3, 0);
		sys(3'h0);
	endtask : sc_lcd
	task automatic sc_hs();
		dly = 6;
		// Width field below the ready delay, so a fixed width would fail.
		run_acc(1, 0, wv(9, 2, 9, 1), 1, -6, 1, 0);
		run_acc(0, 1, wv(9, 2, 9, 1), 1, -6, 1, 2'h2);
	endtask : sc_hs
	task automatic sc_sdram();
		@(posedge clk);
		sdram_addr <= 16'hbeef;
		sdram_data <= 16'h1234;
		sdram_data_oe <= 1;
		sys(3'h1);
		chk(inner_sdram_controller, 1);
		chk(addr_out, 16'hbeef);
		chk(data_out, 16'h1234);
		chk(data_oe, 1);
		sys(3'h0);
		chk(inner_sdram_controller, 0);
		chk(data_oe, 0);
		// Outer controller owns the muxes again: address and write data.
		wreg(5'h14, 32'h0000c3a5);
		wreg(5'h10, 32'h00123403);
		repeat (2) @(negedge clk);
		chk(addr_out, 16'h1234);
		chk(data_out, 16'hc3a5);
		chk(data_oe, 1);
		repeat (20) @(negedge clk);
		chk(lcd_select_n, 1);
	endtask : sc_sdram
	task automatic report_and_stop();
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : report_and_stop
	// Reset, then the scenarios in turn.
	initial
	begin
		sys_rst = 1;
		avs_read = 0;
		avs_write = 0;
		avs_address = 0;
		avs_writedata = 0;
		sdram_addr = 0;
		sdram_data = 0;
		sdram_data_oe = 0;
		pol_f = 0;
		pol_g = 0;
		dly = 1;
		repeat (10) @(posedge clk);
		sys_rst <= 0;
		sc_regs();
		sc_flash();
		sc_lcd();
		sc_hs();
		sc_sdram();
		report_and_stop();
	end
endmodule : tb
`default_nettype wire
